// ### rtl/ext_int_pkg.sv
// Package for the two-channel external interrupt latch unit.
// Assumes a 32-bit AXI4-Lite register bus and a 100 MHz single clock.
package ext_int_pkg;
  // Register byte offsets
  localparam logic [7:0] ext_int_status_ctrl_off = 8'h00;
  localparam logic [7:0] ext_int_status_ctrl_b_off = 8'h04;
  localparam logic [7:0] break_flag_ctrl_off = 8'h08;
  // Field positions; trigger, mask, ack and flag shared by both status/control registers
  localparam int trigger_sel_pos = 0;
  localparam int request_mask_pos = 1;
  localparam int ack_pos = 2;
  localparam int pending_flag_pos = 3;
  localparam int pin_level_pos = 4;
  localparam int pullup_disable_pos = 5;
  localparam int break_clear_enable_pos = 0;
  localparam int break_state_pos = 1;
  // Reset values
  localparam logic reset_trigger_sel = 1'b0;
  localparam logic reset_request_mask = 1'b0;
  localparam logic reset_pullup_disable = 1'b0;
  localparam logic reset_break_clear_enable = 1'b0;
  localparam logic reset_latch = 1'b0;
  // Synchroniser depth in flip-flops
  localparam int sync_stages = 2;
  localparam int num_channels = 2;
  // AXI responses
  localparam logic [1:0] resp_okay = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;
endpackage : ext_int_pkg

// ### rtl/ext_int_channel.sv
// One external interrupt channel: synchroniser, edge/level detect, latch.
// Assumes the pin is asynchronous and active low; acks are one-cycle pulses.
`timescale 1ns/1ps
module ext_int_channel
  import ext_int_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pin
  input wire logic pin_n,
  // Control
  input wire logic trigger_sel,
  input wire logic vector_ack,
  input wire logic soft_ack,
  // Status
  output logic latch,
  output logic pin_sync
);
  typedef struct packed {
    logic [sync_stages-1:0] sync;
    logic prev;
    logic latch;
    logic acked;
  } chan_state_t;

  chan_state_t state;
  chan_state_t next_state;
  logic falling;
  logic ack;

  assign pin_sync = state.sync[sync_stages-1];
  assign latch = state.latch;

  // Next state; set beats clear so an edge meeting an ack is kept
  always_comb
  begin
    next_state = state;
    next_state.sync = {state.sync[sync_stages-2:0], pin_n};
    next_state.prev = state.sync[sync_stages-1];
    falling = state.prev && !state.sync[sync_stages-1];
    ack = vector_ack || soft_ack;
    if (ack)
    begin
      next_state.latch = 1'b0;
      next_state.acked = trigger_sel;
    end
    // Level mode: an ack seen while low completes once the pin is back high
    if (state.acked && state.sync[sync_stages-1])
    begin
      next_state.latch = 1'b0;
      next_state.acked = 1'b0;
    end
    if (!trigger_sel)
    begin
      next_state.acked = 1'b0;
    end
    if (falling)
    begin
      next_state.latch = 1'b1;
    end
    if (trigger_sel && !state.sync[sync_stages-1])
    begin
      next_state.latch = 1'b1;
    end
  end

  // Pin samples reset high; a pin held low through reset gives a falling edge after reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state.sync <= '1;
      state.prev <= 1'b1;
      state.latch <= reset_latch;
      state.acked <= 1'b0;
    end
    else
    begin
      state <= next_state;
    end
  end

  a_edge_sets: assert property (@(posedge aclk) disable iff (!aresetn)
    (state.prev && !state.sync[sync_stages-1]) |=> latch)
    else $error("falling edge did not set latch");
  a_edge_ack_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    (!trigger_sel && ack && !(state.prev && !state.sync[sync_stages-1])) |=> !latch)
    else $error("edge mode ack did not clear latch");
  a_level_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    (trigger_sel && !pin_sync) |=> latch)
    else $error("level mode low pin not pending");
  a_reset_clears: assert property (@(posedge aclk)
    !aresetn |=> !latch)
    else $error("reset did not clear latch");
endmodule : ext_int_channel

// ### rtl/ext_int_latch_unit.sv
// Two-channel external interrupt latch unit with AXI4-Lite registers.
// Assumes a CPU that pulses vector_fetch per channel and a break-state level.
// Function
// - Two independent channels, each with latch, mask, flag, ack and mode bit.
// - Low pin level can set the channel latch per selected sensitivity.
// - Vector fetch clears only the latch that caused it.
// - Writing one to the ack bit clears that channel latch.
// - Reset clears latches and mode bits even with pin held low.
// - Edge mode: falling edges only; any ack clears latch at once.
// - Level mode: request stays until ack and pin high, any order.
// - Level mode keeps request pending while pin stays low.
// - Software ack does not block later falling edges from latching.
// - Mask bit set withholds request from priority logic.
// - Flag reads latch state regardless of mask.
// - First pin level visible to branch instructions; second not.
// - First pullup always on; second switched by its control bit.
// - With break clear enable, break-state acks clear latches as they do outside break.
// - Without break clear enable, break-state software acks change nothing.
// - Ack bits are write-only, read zero, cleared by reset.
// - Reset clears mask bits; writing one disables requests.
// - Writing one to pullup control disables second pullup; reset clears it.
`timescale 1ns/1ps
module ext_int_latch_unit
  import ext_int_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt pins, active low
  input wire logic ext_int_pin_a_n,
  input wire logic ext_int_pin_b_n,
  // CPU side
  input wire logic [1:0] vector_fetch,
  input wire logic break_state,
  output logic [1:0] irq_request,
  output logic pin_level_a,
  // Pad control
  output logic pullup_en_a,
  output logic pullup_en_b
);
  typedef struct packed {
    logic awready;
    logic wready;
    logic have_aw;
    logic have_w;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] trigger_sel;
    logic [1:0] request_mask;
    logic pullup_disable;
    logic break_clear_enable;
    logic [1:0] irq_request;
    logic pin_level_a;
    logic pullup_en_a;
    logic pullup_en_b;
  } unit_state_t;

  unit_state_t state;
  unit_state_t next_state;
  logic [1:0] soft_ack;
  logic [1:0] latch;
  logic [1:0] pin_sync;
  logic do_write;
  logic [1:0] pin_n;

  assign pin_n = {ext_int_pin_b_n, ext_int_pin_a_n};

  // Register index decode, used by read and write paths
  function automatic logic [1:0] decode(input logic [7:0] addr);
    unique case (addr)
      ext_int_status_ctrl_off: decode = 2'h0;
      ext_int_status_ctrl_b_off: decode = 2'h1;
      break_flag_ctrl_off: decode = 2'h2;
      default: decode = 2'h3;
    endcase
  endfunction : decode

  // Channel instances; acks are combinational so the clear lands one edge after the write
  genvar ch;
  generate
    for (ch = 0; ch < num_channels; ch++)
    begin : g_chan
      ext_int_channel u_chan (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_n(pin_n[ch]),
        .trigger_sel(state.trigger_sel[ch]),
        .vector_ack(vector_fetch[ch]),
        .soft_ack(soft_ack[ch]),
        .latch(latch[ch]),
        .pin_sync(pin_sync[ch])
      );
    end
  endgenerate

  assign do_write = state.have_aw && state.have_w && !state.bvalid;

  // Software ack pulses, gated by break state
  always_comb
  begin
    soft_ack = 2'b00;
    if (do_write && state.wstrb[0] && (!break_state || state.break_clear_enable))
    begin
      if (decode(state.awaddr) == 2'h0)
      begin
        soft_ack[0] = state.wdata[ack_pos];
      end
      if (decode(state.awaddr) == 2'h1)
      begin
        soft_ack[1] = state.wdata[ack_pos];
      end
    end
  end

  // Bus handshakes, register updates and output staging
  always_comb
  begin
    next_state = state;
    // Write address and data accepted in either order or together
    next_state.awready = !state.have_aw && !s_axi_awready;
    next_state.wready = !state.have_w && !s_axi_wready;
    if (s_axi_awvalid && state.awready)
    begin
      next_state.have_aw = 1'b1;
      next_state.awaddr = s_axi_awaddr;
      next_state.awready = 1'b0;
    end
    if (s_axi_wvalid && state.wready)
    begin
      next_state.have_w = 1'b1;
      next_state.wdata = s_axi_wdata;
      next_state.wstrb = s_axi_wstrb;
      next_state.wready = 1'b0;
    end
    if (do_write)
    begin
      next_state.have_aw = 1'b0;
      next_state.have_w = 1'b0;
      next_state.bvalid = 1'b1;
      next_state.bresp = resp_okay;
      if (state.wstrb[0])
      begin
        unique case (decode(state.awaddr))
          2'h0:
          begin
            next_state.trigger_sel[0] = state.wdata[trigger_sel_pos];
            next_state.request_mask[0] = state.wdata[request_mask_pos];
          end
          2'h1:
          begin
            next_state.trigger_sel[1] = state.wdata[trigger_sel_pos];
            next_state.request_mask[1] = state.wdata[request_mask_pos];
            next_state.pullup_disable = state.wdata[pullup_disable_pos];
          end
          2'h2:
          begin
            next_state.break_clear_enable = state.wdata[break_clear_enable_pos];
          end
          2'h3:
          begin
            next_state.bresp = resp_slverr;
          end
        endcase
      end
      else if (decode(state.awaddr) == 2'h3)
      begin
        next_state.bresp = resp_slverr;
      end
    end
    if (state.bvalid && s_axi_bready)
    begin
      next_state.bvalid = 1'b0;
    end
    // Read path: one read at a time, answer one edge after address is taken
    // Ready does not wait for valid to drop, so a master holding valid is never stuck
    next_state.arready = !state.rvalid;
    if (s_axi_arvalid && state.arready)
    begin
      next_state.arready = 1'b0;
      next_state.rvalid = 1'b1;
      next_state.rresp = resp_okay;
      next_state.rdata = 32'h0000_0000; // Ack and reserved bits read zero
      unique case (decode(s_axi_araddr))
        2'h0:
        begin
          next_state.rdata[trigger_sel_pos] = state.trigger_sel[0];
          next_state.rdata[request_mask_pos] = state.request_mask[0];
          next_state.rdata[pending_flag_pos] = latch[0];
          next_state.rdata[pin_level_pos] = pin_sync[0];
        end
        2'h1:
        begin
          next_state.rdata[trigger_sel_pos] = state.trigger_sel[1];
          next_state.rdata[request_mask_pos] = state.request_mask[1];
          next_state.rdata[pending_flag_pos] = latch[1];
          next_state.rdata[pullup_disable_pos] = state.pullup_disable;
        end
        2'h2:
        begin
          next_state.rdata[break_clear_enable_pos] = state.break_clear_enable;
          next_state.rdata[break_state_pos] = break_state;
        end
        2'h3:
        begin
          next_state.rresp = resp_slverr;
        end
      endcase
    end
    if (state.rvalid && s_axi_rready)
    begin
      next_state.rvalid = 1'b0;
    end
    // Masked requests stay off the priority logic; flags are unaffected
    next_state.irq_request = latch & ~state.request_mask;
    next_state.pin_level_a = pin_sync[0];
    next_state.pullup_en_a = 1'b1;
    next_state.pullup_en_b = !state.pullup_disable;
  end

  // State register; mode and mask bits clear on reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= '0;
      state.trigger_sel <= {2{reset_trigger_sel}};
      state.request_mask <= {2{reset_request_mask}};
      state.pullup_disable <= reset_pullup_disable;
      state.break_clear_enable <= reset_break_clear_enable;
      state.pin_level_a <= 1'b1;
      state.pullup_en_a <= 1'b1;
      state.pullup_en_b <= 1'b1;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Outputs straight from flip-flops
  assign s_axi_awready = state.awready;
  assign s_axi_wready = state.wready;
  assign s_axi_bresp = state.bresp;
  assign s_axi_bvalid = state.bvalid;
  assign s_axi_arready = state.arready;
  assign s_axi_rdata = state.rdata;
  assign s_axi_rresp = state.rresp;
  assign s_axi_rvalid = state.rvalid;
  assign irq_request = state.irq_request;
  assign pin_level_a = state.pin_level_a;
  assign pullup_en_b = state.pullup_en_b;
  // First pullup is permanent, but registered like every other output
  assign pullup_en_a = state.pullup_en_a;

  sequence s_ack_in_break;
    do_write && break_state && !state.break_clear_enable && decode(state.awaddr) == 2'h0;
  endsequence

  a_mask_gates: assert property (@(posedge aclk) disable iff (!aresetn)
    state.request_mask[0] |=> !irq_request[0])
    else $error("masked request reached priority logic");
  a_unmasked_forward: assert property (@(posedge aclk) disable iff (!aresetn)
    (latch[1] && !state.request_mask[1]) |=> irq_request[1])
    else $error("unmasked request not forwarded");
  a_break_protect: assert property (@(posedge aclk) disable iff (!aresetn)
    s_ack_in_break |-> soft_ack == 2'b00)
    else $error("ack acted in break without clear enable");
  a_break_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_write && break_state && state.break_clear_enable && state.wstrb[0]
      && decode(state.awaddr) == 2'h1 && state.wdata[ack_pos]) |-> soft_ack[1])
    else $error("ack ignored in break with clear enable");
  a_ack_reads_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> !s_axi_rdata[ack_pos])
    else $error("ack bit read as one");
  a_pullup_b: assert property (@(posedge aclk) disable iff (!aresetn)
    state.pullup_disable |=> !pullup_en_b)
    else $error("pullup not disabled");
  a_pin_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 pin_level_a == $past(pin_sync[0]))
    else $error("pin level a not forwarded");
  a_mode_reset: assert property (@(posedge aclk)
    !aresetn |=> state.trigger_sel == 2'b00 && state.request_mask == 2'b00)
    else $error("mode or mask not cleared by reset");

  // Bus answer steps: a write is answered once both halves are in
  sequence s_write_complete;
    state.have_aw && state.have_w && !state.bvalid;
  endsequence

  sequence s_read_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    s_write_complete |=> s_axi_bvalid)
    else $error("write not answered");
  a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    s_read_taken |=> s_axi_rvalid)
    else $error("read not answered");
  // Responses must stand until the master takes them
  a_bvalid_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_rvalid_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid)
    else $error("read response dropped early");
  a_read_slverr: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_read_taken and (decode(s_axi_araddr) == 2'h3)) |=> s_axi_rresp == resp_slverr)
    else $error("unmapped read not refused");
  a_pullup_a: assert property (@(posedge aclk) disable iff (!aresetn)
    1'b1 |=> pullup_en_a)
    else $error("first pullup not enabled");
  a_irq_follows: assert property (@(posedge aclk) disable iff (!aresetn)
    (!latch[0] && !latch[1]) |=> irq_request == 2'b00)
    else $error("request without latch");
endmodule : ext_int_latch_unit

// ### tb/ext_int_source.sv
// Model of the external interrupt sources that pull the two pins low.
// Assumes the bench commands each source; a released pin follows its pullup.
`timescale 1ns/1ps
module ext_int_source
(
  // Clock
  input wire logic aclk,
  // Commands and pad state
  input wire logic [1:0] pull_low,
  input wire logic pullup_a,
  input wire logic pullup_b,
  // Pins, active low
  output logic pin_a_n,
  output logic pin_b_n
);
  logic float_lvl = 1'h0;
  // Floating pin wanders each cycle rather than keeping a stale level
  always @(posedge aclk)
    float_lvl <= ~float_lvl;
  // Open-drain sources; bench must hold pin b low while its pullup is off
  assign pin_a_n = pull_low[0] ? 1'h0 : (pullup_a ? 1'h1 : float_lvl);
  assign pin_b_n = pull_low[1] ? 1'h0 : (pullup_b ? 1'h1 : float_lvl);
endmodule : ext_int_source

// ### tb/external_interrupt_latch_unit_tb.sv
// Self-checking bench for the two-channel external interrupt latch unit.
// Assumes the source model on the pins and a behavioural model kept here.
`timescale 1ns/1ps
module external_interrupt_latch_unit_tb;
  import ext_int_pkg::*;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, irq_request, rs;
  logic [1:0] vector_fetch = 2'h0, pull_low = 2'h0;
  logic break_state = 1'h0;
  logic pin_a_n, pin_b_n, pin_level_a, pullup_en_a, pullup_en_b;
  int n_mismatch = 0, check_count = 0;
  int lat[2], mode[2], msk[2], ackd[2], pud, bce;

  // 100 MHz clock
  always #5 aclk = ~aclk;

  ext_int_latch_unit dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .ext_int_pin_a_n(pin_a_n), .ext_int_pin_b_n(pin_b_n),
    .vector_fetch(vector_fetch), .break_state(break_state), .irq_request(irq_request),
    .pin_level_a(pin_level_a), .pullup_en_a(pullup_en_a), .pullup_en_b(pullup_en_b));

  ext_int_source src (.aclk(aclk), .pull_low(pull_low), .pullup_a(pullup_en_a), .pullup_b(pullup_en_b),
    .pin_a_n(pin_a_n), .pin_b_n(pin_b_n));

  task automatic close_out;
    $display("counts: checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [7:0] off(input int c);
    off = (c == 0) ? ext_int_status_ctrl_off : ext_int_status_ctrl_b_off;
  endfunction : off

  // Model acknowledge; software acks are dropped in break unless enabled
  task automatic mack(input int c, input int sw);
    if (!(sw != 0 && break_state && bce == 0))
    begin
      if (mode[c] == 0 || !pull_low[c])
        lat[c] = 0;
      else
        ackd[c] = 1;
    end
  endtask : mack

  // Model register write
  task automatic mwrite(input logic [7:0] a, input logic [31:0] d);
    int c;
    c = (a == ext_int_status_ctrl_off) ? 0 : 1;
    if (a == ext_int_status_ctrl_off || a == ext_int_status_ctrl_b_off)
    begin
      mode[c] = d[trigger_sel_pos];
      msk[c] = d[request_mask_pos];
      if (c == 1)
        pud = d[pullup_disable_pos];
      if (d[ack_pos])
        mack(c, 1);
    end
    if (a == break_flag_ctrl_off)
      bce = d[break_clear_enable_pos];
  endtask : mwrite

  function automatic logic [31:0] exp_reg(input int c);
    exp_reg = 32'h0;
    exp_reg[trigger_sel_pos] = mode[c][0];
    exp_reg[request_mask_pos] = msk[c][0];
    exp_reg[pending_flag_pos] = lat[c][0];
    if (c == 0)
      exp_reg[pin_level_pos] = ~pull_low[0];
    else
      exp_reg[pullup_disable_pos] = pud[0];
  endfunction : exp_reg

  // Write: address and data offered together, each released when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'h0;
    end
    while (s_axi_bvalid !== 1'h1 && n < 50);
    s_axi_bready <= 1'h0;
    if (n >= 50)
      n_mismatch++;
    chk({30'h0, s_axi_bresp}, {30'h0, resp_okay});
    mwrite(a, d);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready)
        s_axi_arvalid <= 1'h0;
    end
    while (s_axi_rvalid !== 1'h1 && n < 50);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
    if (n >= 50)
      n_mismatch++;
  endtask : axi_rd

  // Pin change, held long enough to pass the synchroniser
  task automatic mpin(input int c, input logic low);
    if (low)
    begin
      lat[c] = 1;
      ackd[c] = 0;
    end
    else if (mode[c] != 0 && ackd[c] != 0)
    begin
      lat[c] = 0;
      ackd[c] = 0;
    end
    pull_low[c] <= low;
    repeat (4) @(posedge aclk);
  endtask : mpin

  task automatic vf(input int c);
    vector_fetch[c] <= 1'h1;
    @(posedge aclk);
    vector_fetch <= 2'h0;
    mack(c, 0);
  endtask : vf

  // Compare every register and output with the model
  task automatic check_all;
    repeat (6) @(posedge aclk);
    axi_rd(ext_int_status_ctrl_off, rd, rs);
    chk(rd, exp_reg(0));
    axi_rd(ext_int_status_ctrl_b_off, rd, rs);
    chk(rd, exp_reg(1));
    axi_rd(break_flag_ctrl_off, rd, rs);
    chk(rd, {30'h0, break_state, bce[0]});
    chk({28'h0, irq_request, pin_level_a, pullup_en_b}, {28'h0, lat[1][0] & ~msk[1][0],
      lat[0][0] & ~msk[0][0], ~pull_low[0], ~pud[0]});
    chk({31'h0, pullup_en_a}, 32'h1);
  endtask : check_all

  // Reset; any pin still held low is released midway
  task automatic do_reset;
    aresetn <= 1'h0;
    repeat (8) @(posedge aclk);
    chk({30'h0, irq_request}, 32'h0);
    pull_low <= 2'h0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    lat = '{0, 0};
    mode = '{0, 0};
    msk = '{0, 0};
    ackd = '{0, 0};
    pud = 0;
    bce = 0;
    repeat (3) @(posedge aclk);
  endtask : do_reset

  // Watchdog
  initial
  begin
    #500_000;
    n_mismatch++;
    close_out();
  end

  initial
  begin
    void'($urandom(83020));
    do_reset();
    check_all();
    axi_rd(8'h0c, rd, rs);
    chk({rd[31:2], rs}, {30'h0, resp_slverr});
    $display("test reset done");
    mpin(0, 1'h1);
    mpin(1, 1'h1);
    check_all();
    for (int c = 0; c < 2; c++)
    begin
      axi_wr(off(c), 32'h2);
      check_all();
      axi_wr(off(c), 32'h4);
      check_all();
      mpin(c, 1'h0);
      mpin(c, 1'h1);
      check_all();
    end
    vf(0);
    check_all();
    vf(1);
    check_all();
    mpin(0, 1'h0);
    mpin(1, 1'h0);
    $display("test edge done");
    axi_wr(off(0), 32'h1);
    mpin(0, 1'h1);
    check_all();
    axi_wr(off(0), 32'h3);
    axi_wr(off(0), 32'h5);
    check_all();
    mpin(0, 1'h0);
    check_all();
    mpin(0, 1'h1);
    mpin(0, 1'h0);
    check_all();
    vf(0);
    check_all();
    mpin(0, 1'h1);
    do_reset();
    check_all();
    $display("test level done");
    break_state <= 1'h1;
    mpin(1, 1'h1);
    axi_wr(off(1), 32'h4);
    check_all();
    axi_wr(break_flag_ctrl_off, 32'h1);
    axi_wr(off(1), 32'h4);
    check_all();
    break_state <= 1'h0;
    check_all();
    axi_wr(off(1), 32'h20);
    check_all();
    mpin(0, 1'h1);
    check_all();
    axi_wr(off(1), 32'h4);
    mpin(1, 1'h0);
    mpin(0, 1'h0);
    axi_wr(break_flag_ctrl_off, 32'h0);
    $display("test break and pad done");
    // Random control values; pullup bit kept clear so pin b never floats
    repeat (6)
    begin
      axi_wr(off($urandom_range(0, 1)), $urandom & 32'h7);
      check_all();
    end
    $display("test random done");
    close_out();
  end
endmodule : external_interrupt_latch_unit_tb
